// File: printer_rx_regs.svh
// widths, sizes, field values and timing counts of the host receive interface
`ifndef PRINTER_RX_REGS_SVH
`define PRINTER_RX_REGS_SVH

`define RX_ADDR_W        10
`define RX_DEPTH         11'h400
`define RX_BUSY_FREE     11'h100
`define XON_CHAR         8'h11
`define XOFF_CHAR        8'h13
`define CLK_PERIOD_NS    8
`define XON_PERIOD_MS    1000
`define XON_PERIOD_CYC   ((`XON_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define ACK_PULSE_CYC    4
`define REL_NATIVE_CYC   2
`define REL_IMPACT_CYC   8
`define PAR_CNT_W        16
`define XON_CNT_W        27

`endif

// File: printer_rx_pkg.sv
// state types of the host receive interface
package printer_rx_pkg;

  typedef enum logic [1:0] {
    PAR_IDLE  = 2'h0,
    PAR_WRITE = 2'h1,
    PAR_ACK   = 2'h3,
    PAR_HOLD  = 2'h2
  } par_state_t;

  typedef enum logic [1:0] {
    NIB_WAIT_LO = 2'h0,
    NIB_LO      = 2'h1,
    NIB_WAIT_HI = 2'h3,
    NIB_HI      = 2'h2
  } nib_state_t;

endpackage

// File: rx_buffer_mem.sv
// receive buffer storage with registered read data
`timescale 1ns/1ns
`include "printer_rx_regs.svh"

module rx_buffer_mem (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    clk_en_i,
  // write side
  input  wire logic                    wr_en_i,
  input  wire logic [`RX_ADDR_W-1:0]   wr_addr_i,
  input  wire logic [7:0]              wr_data_i,
  // read side
  input  wire logic                    rd_en_i,
  input  wire logic [`RX_ADDR_W-1:0]   rd_addr_i,
  output logic      [7:0]              rd_data_o
);

  logic [7:0] mem_q [0:(1<<`RX_ADDR_W)-1];

  always_ff @(posedge clk_i) begin
    if (clk_en_i && wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 8'h00;
    end else if (clk_en_i && rd_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// File: printer_host_interface_rx.sv
// host receive interface: parallel forward port, nibble id channel, serial pacing
`timescale 1ns/1ns
`include "printer_rx_regs.svh"

// Functional notes
// - host data taken only by forward strobe handshake; no bidirectional data transfer.
// - reverse nibble channel only returns id bytes, only with parallel selected.
// - each reverse byte goes out as two 4-bit halves on status lines.
// - after HostBusy falls, drive PtrClk low with the low nibble.
// - after the second HostBusy fall, present the high nibble.
// - after HostBusy rises with no more id bytes, sit idle, DataAvail high.
// - strobe falling edge latches the data byte and raises BUSY.
// - byte stored, then ACKNLG pulse, then BUSY released after mode delay.
// - interface select routes parallel or serial bytes into the buffer.
// - switch 8 selects DTR pacing or XON/XOFF for serial path.
// - under DTR pacing serial bytes accepted only while DSR is high.
// - DTR high when ready, low when busy, errored or offline.
// - XON/XOFF mode holds DTR and RTS high.
// - flow characters sent only while CTS is high.
// - send 11H when ready, 13H when busy, repeated every second.
// - serial bytes discarded while DSR is low, whatever DTR shows.
// - busy shown once free buffer space is 256 bytes or fewer.
// - while busy keep storing until full, then drop further bytes.
// - ready again once more than 256 bytes are free.
module printer_host_interface_rx #(
  parameter int unsigned ACK_CYC        = `ACK_PULSE_CYC,
  parameter int unsigned REL_NATIVE_CYC = `REL_NATIVE_CYC,
  parameter int unsigned REL_IMPACT_CYC = `REL_IMPACT_CYC,
  parameter int unsigned XON_PERIOD_CYC = `XON_PERIOD_CYC
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  // configuration and status
  input  wire logic       parallel_sel_i,
  input  wire logic       xon_mode_i,
  input  wire logic       impact_emulation_mode_i,
  input  wire logic       printer_error_i,
  // parallel forward port
  input  wire logic [7:0] pdata_i,
  input  wire logic       strobe_n_i,
  output logic            busy_o,
  output logic            ack_n_o,
  // nibble reverse channel
  input  wire logic       host_busy_i,
  output logic            ptr_clk_o,
  output logic [3:0]      status_nib_o,
  output logic            data_avail_o,
  // identification bytes to send back
  input  wire logic       id_valid_i,
  input  wire logic [7:0] id_data_i,
  output logic            id_ready_o,
  // serial receiver and transmitter
  input  wire logic       ser_valid_i,
  input  wire logic [7:0] ser_data_i,
  input  wire logic       dsr_i,
  input  wire logic       cts_i,
  output logic            dtr_o,
  output logic            rts_o,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  input  wire logic       tx_ready_i,
  // received byte stream to the controller
  output logic            rd_valid_o,
  output logic [7:0]      rd_data_o,
  input  wire logic       rd_ready_i
);

  printer_rx_pkg::par_state_t   par_state_q;
  printer_rx_pkg::nib_state_t   nib_state_q;
  logic                         strobe_q;
  logic                         host_busy_q;
  logic [7:0]                   par_byte_q;
  logic [`PAR_CNT_W-1:0]        par_cnt_q;
  logic [7:0]                   nib_byte_q;
  logic [`RX_ADDR_W-1:0]        wr_ptr_q;
  logic [`RX_ADDR_W-1:0]        rd_ptr_q;
  logic [`RX_ADDR_W:0]          used_q;
  logic                         rd_inflight_q;
  logic [1:0]                   ob_cnt_q;
  logic [7:0]                   ob_data_q [0:1];
  logic [`XON_CNT_W-1:0]        xon_cnt_q;
  logic [7:0]                   last_char_q;
  logic [7:0]                   mem_rdata;

  // edge detection and buffer state
  wire                   strobe_fall = strobe_q & ~strobe_n_i;
  wire                   hb_fall     = host_busy_q & ~host_busy_i;
  wire [`RX_ADDR_W:0]    free_space  = `RX_DEPTH - used_q;
  wire                   buf_busy    = (free_space <= `RX_BUSY_FREE);
  wire                   buf_full    = (used_q == `RX_DEPTH);
  wire                   dev_busy    = buf_busy | printer_error_i;

  // input routing
  wire       par_wr   = (par_state_q == printer_rx_pkg::PAR_WRITE);
  wire       ser_take = ~parallel_sel_i & ser_valid_i & dsr_i;
  wire       wr_req   = parallel_sel_i ? par_wr : ser_take;
  wire [7:0] wr_data  = parallel_sel_i ? par_byte_q : ser_data_i;
  wire       wr_en    = wr_req & ~buf_full;

  // read side and two-entry output buffer
  wire       rd_room  = (ob_cnt_q + {1'b0, rd_inflight_q}) < 2'h2;
  wire       rd_en    = (used_q != '0) & rd_room;
  wire       ob_pop   = rd_valid_o & rd_ready_i;
  wire [1:0] ob_idx   = ob_cnt_q - {1'b0, ob_pop};
  wire [`RX_ADDR_W:0] used_d = used_q + {{`RX_ADDR_W{1'b0}}, wr_en}
                             - {{`RX_ADDR_W{1'b0}}, rd_en};

  // parallel counter loads
  wire [`PAR_CNT_W-1:0] ack_load = `PAR_CNT_W'(ACK_CYC - 1);
  wire [`PAR_CNT_W-1:0] rel_load = impact_emulation_mode_i
                                 ? `PAR_CNT_W'(REL_IMPACT_CYC - 1)
                                 : `PAR_CNT_W'(REL_NATIVE_CYC - 1);

  // serial flow characters
  wire       ser_xon   = xon_mode_i & ~parallel_sel_i;
  wire [7:0] cur_char  = dev_busy ? `XOFF_CHAR : `XON_CHAR;
  wire       xon_tick  = (xon_cnt_q == `XON_CNT_W'(XON_PERIOD_CYC - 1));
  wire       tx_start  = ser_xon & cts_i & ~tx_valid_o
                       & (xon_tick | (cur_char != last_char_q));

  rx_buffer_mem u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_ptr_q),
    .wr_data_i (wr_data),
    .rd_en_i   (rd_en),
    .rd_addr_i (rd_ptr_q),
    .rd_data_o (mem_rdata)
  );

  // parallel forward handshake, data only flows host to device
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      par_state_q <= printer_rx_pkg::PAR_IDLE;
      par_byte_q  <= 8'h00;
      par_cnt_q   <= '0;
      strobe_q    <= 1'b1;
    end else if (clk_en_i) begin
      strobe_q <= strobe_n_i;
      case (par_state_q)
        printer_rx_pkg::PAR_IDLE: begin
          if (parallel_sel_i && strobe_fall) begin
            par_byte_q  <= pdata_i;
            par_state_q <= printer_rx_pkg::PAR_WRITE;
          end
        end
        printer_rx_pkg::PAR_WRITE: begin
          par_cnt_q   <= ack_load;
          par_state_q <= printer_rx_pkg::PAR_ACK;
        end
        printer_rx_pkg::PAR_ACK: begin
          if (par_cnt_q == '0) begin
            par_cnt_q   <= rel_load;
            par_state_q <= printer_rx_pkg::PAR_HOLD;
          end else begin
            par_cnt_q <= par_cnt_q - 1'b1;
          end
        end
        printer_rx_pkg::PAR_HOLD: begin
          if (par_cnt_q == '0) begin
            par_state_q <= printer_rx_pkg::PAR_IDLE;
          end else begin
            par_cnt_q <= par_cnt_q - 1'b1;
          end
        end
        default: par_state_q <= printer_rx_pkg::PAR_IDLE;
      endcase
    end
  end

  assign ack_n_o = (par_state_q != printer_rx_pkg::PAR_ACK);
  assign busy_o  = (par_state_q != printer_rx_pkg::PAR_IDLE) | dev_busy;

  // nibble reverse channel for id bytes
  assign id_ready_o = parallel_sel_i & id_valid_i & hb_fall
                    & (nib_state_q == printer_rx_pkg::NIB_WAIT_LO);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nib_state_q  <= printer_rx_pkg::NIB_WAIT_LO;
      nib_byte_q   <= 8'h00;
      status_nib_o <= 4'h0;
      ptr_clk_o    <= 1'b1;
      data_avail_o <= 1'b1;
      host_busy_q  <= 1'b1;
    end else if (clk_en_i) begin
      host_busy_q  <= host_busy_i;
      data_avail_o <= ~id_valid_i;
      case (nib_state_q)
        printer_rx_pkg::NIB_WAIT_LO: begin
          if (id_ready_o) begin
            nib_byte_q   <= id_data_i;
            status_nib_o <= id_data_i[3:0];
            ptr_clk_o    <= 1'b0;
            nib_state_q  <= printer_rx_pkg::NIB_LO;
          end
        end
        printer_rx_pkg::NIB_LO: begin
          if (host_busy_i) begin
            ptr_clk_o   <= 1'b1;
            nib_state_q <= printer_rx_pkg::NIB_WAIT_HI;
          end
        end
        printer_rx_pkg::NIB_WAIT_HI: begin
          if (hb_fall) begin
            status_nib_o <= nib_byte_q[7:4];
            ptr_clk_o    <= 1'b0;
            nib_state_q  <= printer_rx_pkg::NIB_HI;
          end
        end
        printer_rx_pkg::NIB_HI: begin
          if (host_busy_i) begin
            ptr_clk_o   <= 1'b1;
            nib_state_q <= printer_rx_pkg::NIB_WAIT_LO;
          end
        end
        default: nib_state_q <= printer_rx_pkg::NIB_WAIT_LO;
      endcase
    end
  end

  // receive buffer pointers and output buffer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      used_q        <= '0;
      rd_inflight_q <= 1'b0;
      ob_cnt_q      <= 2'h0;
      ob_data_q[0]  <= 8'h00;
      ob_data_q[1]  <= 8'h00;
    end else if (clk_en_i) begin
      if (wr_en) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (rd_en) rd_ptr_q <= rd_ptr_q + 1'b1;
      used_q        <= used_d;
      rd_inflight_q <= rd_en;
      ob_cnt_q      <= ob_cnt_q + {1'b0, rd_inflight_q} - {1'b0, ob_pop};
      if (ob_pop) ob_data_q[0] <= ob_data_q[1];
      if (rd_inflight_q) ob_data_q[ob_idx[0]] <= mem_rdata;
    end
  end

  assign rd_valid_o = (ob_cnt_q != 2'h0);
  assign rd_data_o  = ob_data_q[0];

  // serial pacing lines
  assign dtr_o = xon_mode_i | ~dev_busy;
  assign rts_o = 1'b1;

  // flow character sender, repeats each period
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xon_cnt_q   <= '0;
      last_char_q <= 8'h00;
      tx_valid_o  <= 1'b0;
      tx_data_o   <= 8'h00;
    end else if (clk_en_i) begin
      xon_cnt_q <= xon_tick ? '0 : xon_cnt_q + 1'b1;
      if (tx_start) begin
        tx_valid_o  <= 1'b1;
        tx_data_o   <= cur_char;
        last_char_q <= cur_char;
      end else if (tx_valid_o && tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_i iff clk_en_i); endclocking
  default disable iff (!reset_n_i);

  chk_strobe_busy: assert property (
    parallel_sel_i && strobe_fall && par_state_q == printer_rx_pkg::PAR_IDLE
    |=> busy_o && par_byte_q == $past(pdata_i))
    else $error("strobe fall did not latch data and raise busy");

  chk_ack_after_write: assert property (
    par_wr |=> !ack_n_o && busy_o)
    else $error("acknowledge missing after buffer write");

  chk_nib_low_half: assert property (
    id_ready_o |=> !ptr_clk_o && status_nib_o == $past(id_data_i[3:0]))
    else $error("low nibble not presented with ptr clock low");

  chk_nib_high_half: assert property (
    nib_state_q == printer_rx_pkg::NIB_WAIT_HI && hb_fall
    |=> status_nib_o == nib_byte_q[7:4] && !ptr_clk_o)
    else $error("high nibble not presented after second fall");

  chk_nib_serial_off: assert property (
    !parallel_sel_i |-> !id_ready_o)
    else $error("id byte taken while serial selected");

  chk_xon_lines_high: assert property (
    xon_mode_i |-> dtr_o && rts_o)
    else $error("dtr or rts low in xon mode");

  chk_dtr_busy_mark: assert property (
    !xon_mode_i && dev_busy |-> !dtr_o)
    else $error("dtr high while busy");

  chk_dsr_drop: assert property (
    !parallel_sel_i && !dsr_i |-> !wr_en)
    else $error("serial byte stored while dsr low");

  chk_busy_threshold: assert property (
    free_space <= `RX_BUSY_FREE |-> busy_o)
    else $error("busy not shown at low free space");

  chk_full_drop: assert property (
    buf_full |=> used_q == `RX_DEPTH - $past(rd_en))
    else $error("byte stored into full buffer");

  chk_tx_cts_gate: assert property (
    $rose(tx_valid_o) |-> $past(cts_i) && $past(ser_xon))
    else $error("flow character sent without cts");

  chk_tx_char_value: assert property (
    $rose(tx_valid_o) |-> tx_data_o == ($past(dev_busy) ? `XOFF_CHAR : `XON_CHAR))
    else $error("wrong flow character");

  cov_par_byte: cover property (par_wr ##1 !ack_n_o);
  cov_nib_byte: cover property (id_ready_o ##[1:40] nib_state_q == printer_rx_pkg::NIB_HI);
  cov_xoff_sent: cover property ($rose(tx_valid_o) && tx_data_o == `XOFF_CHAR);
  cov_buf_full: cover property (buf_full);

endmodule

// File: host_par_model.sv
// host model: parallel byte sender and nibble id reader
`timescale 1ns/1ns
module host_par_model (
  // clock
  input  wire logic       clk_i,
  // parallel port
  output logic      [7:0] pdata_o,
  output logic            strobe_n_o,
  input  wire logic       busy_i,
  input  wire logic       ack_n_i,
  // nibble channel
  output logic            host_busy_o,
  input  wire logic       ptr_clk_i
);
  int lag = 0;
  initial begin
    pdata_o = 8'h00;
    strobe_n_o = 1'b1;
    host_busy_o = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    int n;
    for (n = 0; n < 500 && busy_i !== 1'b0; n++) @(negedge clk_i);
    pdata_o = b;
    strobe_n_o = 1'b0;
    for (n = 0; n < 50 && ack_n_i !== 1'b0; n++) @(negedge clk_i);
    strobe_n_o = 1'b1;
    // released lines do not keep the byte
    pdata_o = ~b;
  endtask
  task automatic wait_ptr(input logic v);
    for (int n = 0; n < 30 && ptr_clk_i !== v; n++) @(negedge clk_i);
  endtask
  task automatic nib_read();
    for (int k = 0; k < 2; k++) begin
      host_busy_o = 1'b0;
      wait_ptr(1'b0);
      repeat (lag) @(negedge clk_i);
      host_busy_o = 1'b1;
      wait_ptr(1'b1);
      // let the high level reach the device before the next fall
      @(negedge clk_i);
    end
  endtask
endmodule

// File: printer_host_interface_rx_tb.sv
// self-checking bench of the host receive interface
`timescale 1ns/1ns
module printer_host_interface_rx_tb;
  localparam int REL_N = 2;
  localparam int REL_I = 8;
  logic       clk = 1'b0, reset_n = 1'b0, psel = 1'b1, xon = 1'b0, imp = 1'b0, perr = 1'b0;
  logic       id_valid = 1'b0, ser_valid = 1'b0, dsr = 1'b1, cts = 1'b0;
  logic       tx_ready = 1'b1, rd_ready = 1'b0;
  logic [7:0] id_data = 8'h00, ser_data = 8'h00, pdata, tx_data, rd_data;
  logic       strobe_n, busy, ack_n, hb, ptr_clk, avail, id_ready, dtr, rts, tx_valid, rd_valid;
  logic [3:0] nib;
  int         failures = 0;
  int         check_count = 0;

  always #4 clk = ~clk;

  host_par_model host_u (.clk_i(clk), .pdata_o(pdata), .strobe_n_o(strobe_n), .busy_i(busy),
    .ack_n_i(ack_n), .host_busy_o(hb), .ptr_clk_i(ptr_clk));

  printer_host_interface_rx #(.XON_PERIOD_CYC(50)) dut_u (
    .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1), .parallel_sel_i(psel),
    .xon_mode_i(xon), .impact_emulation_mode_i(imp), .printer_error_i(perr),
    .pdata_i(pdata), .strobe_n_i(strobe_n), .busy_o(busy), .ack_n_o(ack_n),
    .host_busy_i(hb), .ptr_clk_o(ptr_clk), .status_nib_o(nib), .data_avail_o(avail),
    .id_valid_i(id_valid), .id_data_i(id_data), .id_ready_o(id_ready),
    .ser_valid_i(ser_valid), .ser_data_i(ser_data), .dsr_i(dsr), .cts_i(cts),
    .dtr_o(dtr), .rts_o(rts), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .rd_ready_i(rd_ready));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // pops the stream, optionally stalling every other cycle
  task automatic drain(input int lo, input int hi, input logic [7:0] first, input logic stall);
    int got;
    int idle;
    got = 0;
    idle = 0;
    while (idle < 12) begin
      @(negedge clk);
      // ready set here is sampled at the coming rising edge with the head word
      rd_ready = stall ? ~rd_ready : 1'b1;
      if (rd_ready && rd_valid === 1'b1) begin
        chk(rd_data, first + 8'(got));
        got++;
      end
      idle = (rd_valid === 1'b1) ? 0 : idle + 1;
    end
    @(negedge clk);
    rd_ready = 1'b0;
    chk(8'(got >= lo && got <= hi), 8'h01);
  endtask

  task automatic ser_burst(input int n, input logic [7:0] start);
    for (int i = 0; i < n; i++) begin
      ser_valid = 1'b1;
      ser_data = start + 8'(i);
      @(negedge clk);
    end
    ser_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic par_test(input logic mode, input logic [7:0] b);
    int n;
    imp = mode;
    @(negedge clk);
    fork
      host_u.send(b);
      begin
        @(negedge clk);
        chk(busy, 1'b1);
        for (n = 0; n < 20 && ack_n !== 1'b0; n++) @(negedge clk);
        chk(busy, 1'b1);
        for (n = 0; n < 20 && ack_n === 1'b0; n++) @(negedge clk);
        chk(8'(n), 8'h04);
        for (n = 0; n < 20 && busy === 1'b1; n++) @(negedge clk);
        chk(8'(n), mode ? 8'(REL_I) : 8'(REL_N));
      end
    join
    drain(1, 1, b, 1'b0);
  endtask

  task automatic nib_test();
    int n;
    psel = 1'b0;
    id_valid = 1'b1;
    id_data = 8'hA5;
    host_u.nib_read();
    chk({avail, ptr_clk}, 2'b01);
    psel = 1'b1;
    host_u.lag = 3;
    fork
      host_u.nib_read();
      begin
        #1 chk(id_ready, 1'b1);
        @(negedge clk);
        id_valid = 1'b0;
        for (n = 0; n < 30 && ptr_clk !== 1'b0; n++) @(negedge clk);
        chk(nib, 4'h5);
        for (n = 0; n < 30 && ptr_clk !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 30 && ptr_clk !== 1'b0; n++) @(negedge clk);
        chk(nib, 4'hA);
      end
    join
    @(negedge clk);
    chk({avail, ptr_clk}, 2'b11);
  endtask

  task automatic ser_test();
    psel = 1'b0;
    dsr = 1'b0;
    ser_burst(3, 8'h50);
    dsr = 1'b1;
    ser_burst(2, 8'h60);
    psel = 1'b1;
    ser_burst(2, 8'h70);
    psel = 1'b0;
    drain(2, 2, 8'h60, 1'b0);
    chk(dtr, 1'b1);
    perr = 1'b1;
    @(negedge clk);
    chk({dtr, busy}, 2'b01);
    perr = 1'b0;
  endtask

  task automatic xon_test();
    int n;
    xon = 1'b1;
    perr = 1'b1;
    for (n = 0; n < 120 && tx_valid !== 1'b1; n++) @(negedge clk);
    chk(8'(n), 8'h78);
    chk({dtr, rts}, 2'b11);
    perr = 1'b0;
    cts = 1'b1;
    for (n = 0; n < 60 && tx_valid !== 1'b1; n++) @(negedge clk);
    chk(tx_data, 8'h11);
    // first wait reaches a period tick, second measures one full period
    repeat (2) begin
      @(negedge clk);
      for (n = 1; n < 80 && tx_valid !== 1'b1; n++) @(negedge clk);
    end
    chk(8'(n >= 45 && n <= 55), 8'h01);
    chk(tx_data, 8'h11);
    perr = 1'b1;
    @(negedge clk);
    for (n = 0; n < 60 && tx_valid !== 1'b1; n++) @(negedge clk);
    chk(tx_data, 8'h13);
    perr = 1'b0;
    cts = 1'b0;
    xon = 1'b0;
  endtask

  task automatic fill_test();
    int first;
    first = 0;
    psel = 1'b0;
    for (int i = 0; i < 1100; i++) begin
      ser_valid = 1'b1;
      ser_data = 8'(i);
      @(negedge clk);
      if (first == 0 && busy === 1'b1) first = i;
    end
    ser_valid = 1'b0;
    chk(8'(first >= 767 && first <= 770), 8'h01);
    chk(dtr, 1'b0);
    drain(1024, 1026, 8'h00, 1'b1);
    chk({busy, dtr}, 2'b01);
  endtask

  initial begin
    #(8 * 20000);
    failures++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    par_test(1'b0, 8'h3C);
    par_test(1'b1, 8'hC3);
    nib_test();
    ser_test();
    xon_test();
    fill_test();
    test_done();
  end
endmodule
